// ===== rtl/fppbs_pkg.sv
// constants, register map and state types of the flash page program and boot select block
package fppbs_pkg;
  localparam int CLK_MHZ           = 10;
  localparam int ERASE_TIME_US     = 2000;
  localparam int PROG_TIME_US      = 2000;
  localparam int ERASE_CYCLES      = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
  localparam int BOOT_HOLD_US      = 1000;
  localparam int BOOT_PULSE_MIN_US = 1;
  localparam int BOOT_PULSE_MAX_US = 100;
  localparam int BOOT_QUIET_US     = 1000;
  localparam int BOOT_HOLD_CYCLES  = BOOT_HOLD_US * CLK_MHZ;
  localparam int BOOT_QUIET_CYCLES = BOOT_QUIET_US * CLK_MHZ;
  localparam logic [15:0] BOOT_PULSE_MIN_CYCLES = 16'(BOOT_PULSE_MIN_US * CLK_MHZ);
  localparam logic [15:0] BOOT_PULSE_MAX_CYCLES = 16'(BOOT_PULSE_MAX_US * CLK_MHZ);
  localparam int TIMER_W           = 16;
  localparam int PAGE_IDX_W        = 6;
  localparam int PAGE_BYTES        = 64;

  localparam logic [7:0] OFS_CMD_STAT  = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFS_PAGE_DATA = 8'h0C;
  localparam logic [7:0] OFS_BOOT_CFG  = 8'h10;
  localparam logic [7:0] OFS_BOOT_INFO = 8'h14;
  localparam logic [7:0] OFS_SECURE    = 8'h18;

  localparam logic [7:0] CMD_LOAD          = 8'h00;
  localparam logic [7:0] CMD_ERASE_PROGRAM = 8'h68;

  localparam int STAT_OI_BIT      = 0;
  localparam int STAT_SV_BIT      = 1;
  localparam int STAT_HVE_BIT     = 2;
  localparam int STAT_HVA_BIT     = 3;
  localparam int BOOT_STATUS_BIT  = 0;
  localparam int BOOT_VECTOR_LSB  = 8;
  localparam int INFO_LOADER_BIT  = 16;
  localparam int INFO_VALID_BIT   = 17;
  localparam int SECTOR_LSB       = 2;

  localparam logic [3:0]  RESET_STATUS      = 4'h0;
  localparam logic [7:0]  RESET_ADDR        = 8'h00;
  localparam logic [7:0]  RESET_BOOT_VECTOR = 8'h1F;
  localparam logic        RESET_BOOT_STATUS = 1'b0;
  localparam logic [7:0]  RESET_SECURE      = 8'h00;
  localparam logic [7:0]  BOOT_ROM_PAGE     = 8'hFF;
  localparam logic [15:0] BOOT_ROM_ENTRY    = 16'hFF00;
  localparam logic [15:0] START_NORMAL      = 16'h0000;
  localparam logic [7:0]  START_LOW_BYTE    = 8'h00;
  localparam logic [2:0]  LOADER_PULSES     = 3'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FPPBS_IDLE  = 2'b00,
    FPPBS_ERASE = 2'b01,
    FPPBS_PROG  = 2'b10
  } fppbs_cyc_t;

  typedef enum logic [1:0] {
    FPPBS_B_HOLD = 2'b00,
    FPPBS_B_GAP  = 2'b01,
    FPPBS_B_LOW  = 2'b10,
    FPPBS_B_DONE = 2'b11
  } fppbs_boot_t;
endpackage : fppbs_pkg

// ===== rtl/fppbs_pbuf_if.sv
// page buffer access between the controller and the buffer memory
`timescale 1ns/1ps
interface fppbs_pbuf_if;
  logic       clear;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_upd;
  modport ctrl (output clear, wr_en, wr_idx, wr_data, rd_idx, input rd_data, rd_upd);
  modport mem  (input clear, wr_en, wr_idx, wr_data, rd_idx, output rd_data, rd_upd);
endinterface : fppbs_pbuf_if

// ===== rtl/fppbs_page_buf.sv
// 64 byte page buffer with one update flag per byte, registered read
`timescale 1ns/1ps
module fppbs_page_buf (
  input wire logic aclk,
  input wire logic aresetn,
  fppbs_pbuf_if.mem pb
);
  logic [7:0]                      mem [0:fppbs_pkg::PAGE_BYTES-1];
  logic [fppbs_pkg::PAGE_BYTES-1:0] upd;
  logic [fppbs_pkg::PAGE_BYTES-1:0] next_upd;
  logic [7:0]                      rd_data;
  logic                            rd_upd;

  always_comb begin
    next_upd = upd;
    if (pb.clear) begin
      next_upd = '0;
    end else if (pb.wr_en) begin
      next_upd[pb.wr_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd     <= '0;
      rd_data <= 8'h00;
      rd_upd  <= 1'b0;
    end else begin
      upd     <= next_upd;
      rd_data <= mem[pb.rd_idx];
      rd_upd  <= upd[pb.rd_idx];
      for (int i = 0; i < fppbs_pkg::PAGE_BYTES; i++) begin
        if (pb.clear) begin
          mem[i] <= 8'h00;
        end else if (pb.wr_en && (pb.wr_idx == 6'(i))) begin
          mem[i] <= pb.wr_data;
        end
      end
    end
  end

  assign pb.rd_data = rd_data;
  assign pb.rd_upd  = rd_upd;
endmodule : fppbs_page_buf

// ===== rtl/fppbs_boot_sel.sv
// power-up reset pulse counting and start address selection
`timescale 1ns/1ps
module fppbs_boot_sel #(
  parameter int HOLD_CYCLES  = fppbs_pkg::BOOT_HOLD_CYCLES,
  parameter int QUIET_CYCLES = fppbs_pkg::BOOT_QUIET_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rst_pin_n,
  input  wire logic        boot_status,
  input  wire logic [7:0]  boot_vector,
  output logic             loader_mode,
  output logic [15:0]      start_addr,
  output logic             start_valid
);
  fppbs_pkg::fppbs_boot_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [2:0]  pulses, next_pulses;
  logic        ok, next_ok;
  logic        next_loader;
  logic [15:0] next_start;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_pulses = pulses;
    next_ok     = ok;
    next_loader = loader_mode;
    unique case (state)
      fppbs_pkg::FPPBS_B_HOLD: begin
        if (!rst_pin_n) begin
          if (cnt != 16'hFFFF) next_cnt = cnt + 16'h0001;
        end else if (cnt >= 16'(HOLD_CYCLES)) begin
          next_state  = fppbs_pkg::FPPBS_B_GAP;
          next_cnt    = 16'h0000;
          next_pulses = 3'h0;
          next_ok     = 1'b1;
        end else begin
          next_state = fppbs_pkg::FPPBS_B_DONE;
        end
      end
      fppbs_pkg::FPPBS_B_GAP: begin
        if (!rst_pin_n) begin
          next_state = fppbs_pkg::FPPBS_B_LOW;
          next_cnt   = 16'h0001;
        end else if (cnt >= 16'(QUIET_CYCLES - 1)) begin
          next_state  = fppbs_pkg::FPPBS_B_DONE;
          next_loader = ok && (pulses == fppbs_pkg::LOADER_PULSES);
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      fppbs_pkg::FPPBS_B_LOW: begin
        if (!rst_pin_n) begin
          if (cnt != 16'hFFFF) next_cnt = cnt + 16'h0001;
        end else begin
          next_state = fppbs_pkg::FPPBS_B_GAP;
          next_cnt   = 16'h0000;
          if (cnt >= fppbs_pkg::BOOT_PULSE_MIN_CYCLES && cnt <= fppbs_pkg::BOOT_PULSE_MAX_CYCLES) begin
            if (pulses != 3'h7) next_pulses = pulses + 3'h1;
          end else begin
            next_ok = 1'b0;
          end
        end
      end
      fppbs_pkg::FPPBS_B_DONE: begin
        next_state = state;
      end
    endcase
    // loader entry behaves as a set boot status bit
    if (boot_status || loader_mode) begin
      next_start = {boot_vector, fppbs_pkg::START_LOW_BYTE};
    end else begin
      next_start = fppbs_pkg::START_NORMAL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= fppbs_pkg::FPPBS_B_HOLD;
      cnt         <= 16'h0000;
      pulses      <= 3'h0;
      ok          <= 1'b0;
      loader_mode <= 1'b0;
      start_addr  <= fppbs_pkg::START_NORMAL;
      start_valid <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      pulses      <= next_pulses;
      ok          <= next_ok;
      loader_mode <= next_loader;
      start_addr  <= next_start;
      start_valid <= (state == fppbs_pkg::FPPBS_B_DONE);
    end
  end
endmodule : fppbs_boot_sel

// ===== rtl/fppbs_flash_ctrl.sv
// flash command/status register, page buffer load, erase-program sequencer and boot select, on AXI4-Lite
`timescale 1ns/1ps
module fppbs_flash_ctrl #(
  parameter int ERASE_CYCLES      = fppbs_pkg::ERASE_CYCLES,
  parameter int PROG_CYCLES       = fppbs_pkg::PROG_CYCLES,
  parameter int BOOT_HOLD_CYCLES  = fppbs_pkg::BOOT_HOLD_CYCLES,
  parameter int BOOT_QUIET_CYCLES = fppbs_pkg::BOOT_QUIET_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        irq_pending,
  input  wire logic        rst_pin_n,
  input  wire logic        flash_brownout_detect,
  input  wire logic        hv_fault,
  output logic             cpu_stall,
  output logic             flash_erase,
  output logic             flash_strobe,
  output logic [15:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  input  wire logic [15:0] code_addr,
  output logic             boot_rom_select,
  output logic [7:0]       boot_rom_index,
  output logic             boot_rom_entry,
  input  wire logic        icp_clk_in,
  output logic             icp_clk_out,
  output logic             icp_clk_oe,
  input  wire logic        icp_data_in,
  output logic             icp_data_out,
  output logic             icp_data_oe,
  output logic             serial_loader_mode,
  output logic [15:0]      start_addr,
  output logic             start_valid
);
  fppbs_pbuf_if pb ();

  fppbs_pkg::fppbs_cyc_t state, next_state;
  logic [fppbs_pkg::TIMER_W-1:0] timer, next_timer;
  logic [3:0]  status, next_status;
  logic [7:0]  addr_low, next_addr_low;
  logic [7:0]  addr_high, next_addr_high;
  logic [7:0]  secure, next_secure;
  logic [7:0]  boot_vector, next_boot_vector;
  logic        boot_status, next_boot_status;
  logic        load_en, next_load_en;
  logic        walk, next_walk;
  logic [5:0]  widx, next_widx;
  logic        vq, next_vq;
  logic [5:0]  iq, next_iq;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic        do_write, idle, wr_mapped, rd_mapped;
  logic [31:0] rd_mux;
  logic        rom_sel, rom_entry;
  logic [7:0]  rom_idx;

  fppbs_page_buf u_page_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pb      (pb.mem)
  );

  fppbs_boot_sel #(
    .HOLD_CYCLES  (BOOT_HOLD_CYCLES),
    .QUIET_CYCLES (BOOT_QUIET_CYCLES)
  ) u_boot_sel (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .rst_pin_n   (rst_pin_n),
    .boot_status (boot_status),
    .boot_vector (boot_vector),
    .loader_mode (serial_loader_mode),
    .start_addr  (start_addr),
    .start_valid (start_valid)
  );

  assign idle          = (state == fppbs_pkg::FPPBS_IDLE);
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign do_write      = aw_held && w_held && !bvalid;
  assign cpu_stall     = !idle;
  assign flash_erase   = (state == fppbs_pkg::FPPBS_ERASE);
  // only bytes marked updated touch the array
  assign flash_strobe  = vq && pb.rd_upd && !idle;
  assign flash_addr    = {addr_high, addr_low[7:6], iq};
  assign flash_wdata   = pb.rd_data;
  // the serial programming protocol lives outside; pins stay released (enable high)
  assign icp_clk_out   = 1'b0;
  assign icp_clk_oe    = 1'b1;
  assign icp_data_out  = 1'b0;
  assign icp_data_oe   = 1'b1;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign boot_rom_select = rom_sel;
  assign boot_rom_index  = rom_idx;
  assign boot_rom_entry  = rom_entry;

  always_comb begin
    wr_mapped = (aw_addr_q == fppbs_pkg::OFS_CMD_STAT) || (aw_addr_q == fppbs_pkg::OFS_ADDR_LOW) ||
                (aw_addr_q == fppbs_pkg::OFS_ADDR_HIGH) || (aw_addr_q == fppbs_pkg::OFS_PAGE_DATA) ||
                (aw_addr_q == fppbs_pkg::OFS_BOOT_CFG) || (aw_addr_q == fppbs_pkg::OFS_SECURE);
    rd_mapped = 1'b1;
    rd_mux    = 32'h0000_0000;
    unique case (s_axi_araddr)
      fppbs_pkg::OFS_CMD_STAT:  rd_mux = {28'h0000000, status};
      fppbs_pkg::OFS_ADDR_LOW:  rd_mux = {24'h000000, addr_low};
      fppbs_pkg::OFS_ADDR_HIGH: rd_mux = {24'h000000, addr_high};
      fppbs_pkg::OFS_PAGE_DATA: rd_mux = 32'h0000_0000;
      fppbs_pkg::OFS_BOOT_CFG:  rd_mux = {16'h0000, boot_vector, 7'h00, boot_status};
      fppbs_pkg::OFS_BOOT_INFO: rd_mux = {14'h0000, start_valid, serial_loader_mode, start_addr};
      fppbs_pkg::OFS_SECURE:    rd_mux = {24'h000000, secure};
      default:                  rd_mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_state       = state;
    next_timer       = timer;
    next_status      = status;
    next_addr_low    = addr_low;
    next_addr_high   = addr_high;
    next_secure      = secure;
    next_boot_vector = boot_vector;
    next_boot_status = boot_status;
    next_load_en     = load_en;
    next_walk        = walk;
    next_widx        = widx;
    next_vq          = 1'b0;
    next_iq          = widx;
    next_bvalid      = bvalid;
    next_bresp       = bresp;
    next_rvalid      = rvalid;
    next_rdata       = rdata;
    next_rresp       = rresp;
    pb.clear         = 1'b0;
    pb.wr_en         = 1'b0;
    pb.wr_idx        = addr_low[5:0];
    pb.wr_data       = w_data_q[7:0];
    pb.rd_idx        = widx;

    if (bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_mux;
      next_rresp  = rd_mapped ? fppbs_pkg::RESP_OKAY : fppbs_pkg::RESP_SLVERR;
    end

    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_mapped ? fppbs_pkg::RESP_OKAY : fppbs_pkg::RESP_SLVERR;
      // while a cycle runs the processor is stalled, so flash writes are dropped
      if (idle && w_strb_q[0]) begin
        unique case (aw_addr_q)
          fppbs_pkg::OFS_CMD_STAT: begin
            next_status = fppbs_pkg::RESET_STATUS;
            if (w_data_q[7:0] == fppbs_pkg::CMD_LOAD) begin
              pb.clear     = 1'b1;
              next_load_en = 1'b1;
            end else if (w_data_q[7:0] == fppbs_pkg::CMD_ERASE_PROGRAM) begin
              next_load_en = 1'b0;
              if (secure[addr_high[fppbs_pkg::SECTOR_LSB +: 3]]) begin
                next_status[fppbs_pkg::STAT_SV_BIT] = 1'b1;
              end else if (flash_brownout_detect) begin
                next_status[fppbs_pkg::STAT_HVA_BIT] = 1'b1;
              end else begin
                next_state = fppbs_pkg::FPPBS_ERASE;
                next_timer = fppbs_pkg::TIMER_W'(ERASE_CYCLES - 1);
                next_walk  = 1'b1;
                next_widx  = 6'h00;
              end
            end
          end
          fppbs_pkg::OFS_ADDR_LOW:  next_addr_low  = w_data_q[7:0];
          fppbs_pkg::OFS_ADDR_HIGH: next_addr_high = w_data_q[7:0];
          fppbs_pkg::OFS_PAGE_DATA: begin
            if (load_en) begin
              pb.wr_en      = 1'b1;
              next_addr_low = {addr_low[7:6], addr_low[5:0] + 6'h01};
            end
          end
          fppbs_pkg::OFS_BOOT_CFG:  next_boot_status = w_data_q[fppbs_pkg::BOOT_STATUS_BIT];
          fppbs_pkg::OFS_SECURE:    next_secure = w_data_q[7:0];
          default:                  next_status = status;
        endcase
      end
      if (idle && w_strb_q[1] && aw_addr_q == fppbs_pkg::OFS_BOOT_CFG) begin
        next_boot_vector = w_data_q[fppbs_pkg::BOOT_VECTOR_LSB +: 8];
      end
    end

    if (!idle) begin
      // walk the buffer once per phase; the phase time does not depend on the byte count
      if (walk) begin
        next_vq   = 1'b1;
        next_widx = widx + 6'h01;
        if (widx == 6'(fppbs_pkg::PAGE_BYTES - 1)) next_walk = 1'b0;
      end
      if (irq_pending || !rst_pin_n || flash_brownout_detect || hv_fault) begin
        if (irq_pending || !rst_pin_n) next_status[fppbs_pkg::STAT_OI_BIT] = 1'b1;
        if (irq_pending || flash_brownout_detect) next_status[fppbs_pkg::STAT_HVA_BIT] = 1'b1;
        if (hv_fault) next_status[fppbs_pkg::STAT_HVE_BIT] = 1'b1;
        next_state = fppbs_pkg::FPPBS_IDLE;
        next_walk  = 1'b0;
        next_vq    = 1'b0;
      end else if (timer == '0) begin
        if (state == fppbs_pkg::FPPBS_ERASE) begin
          next_state = fppbs_pkg::FPPBS_PROG;
          next_timer = fppbs_pkg::TIMER_W'(PROG_CYCLES - 1);
          next_walk  = 1'b1;
          next_widx  = 6'h00;
        end else begin
          next_state = fppbs_pkg::FPPBS_IDLE;
        end
      end else begin
        next_timer = timer - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= fppbs_pkg::FPPBS_IDLE;
      timer       <= '0;
      status      <= fppbs_pkg::RESET_STATUS;
      addr_low    <= fppbs_pkg::RESET_ADDR;
      addr_high   <= fppbs_pkg::RESET_ADDR;
      secure      <= fppbs_pkg::RESET_SECURE;
      boot_vector <= fppbs_pkg::RESET_BOOT_VECTOR;
      boot_status <= fppbs_pkg::RESET_BOOT_STATUS;
      load_en     <= 1'b0;
      walk        <= 1'b0;
      widx        <= 6'h00;
      vq          <= 1'b0;
      iq          <= 6'h00;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr_q   <= 8'h00;
      w_data_q    <= 32'h0000_0000;
      w_strb_q    <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= fppbs_pkg::RESP_OKAY;
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= fppbs_pkg::RESP_OKAY;
      rom_sel     <= 1'b0;
      rom_idx     <= 8'h00;
      rom_entry   <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      status      <= next_status;
      addr_low    <= next_addr_low;
      addr_high   <= next_addr_high;
      secure      <= next_secure;
      boot_vector <= next_boot_vector;
      boot_status <= next_boot_status;
      load_en     <= next_load_en;
      walk        <= next_walk;
      widx        <= next_widx;
      vq          <= next_vq;
      iq          <= next_iq;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      rom_sel   <= (code_addr[15:8] == fppbs_pkg::BOOT_ROM_PAGE);
      rom_idx   <= code_addr[7:0];
      rom_entry <= (code_addr == fppbs_pkg::BOOT_ROM_ENTRY);
    end
  end
endmodule : fppbs_flash_ctrl

// ===== verification/fppbs_flash_ctrl_asserts.sv
// assertion checker for the flash page program and boot select block
`timescale 1ns/1ps
module fppbs_chk #(
  parameter int ERASE_CYCLES = 100,
  parameter int PROG_CYCLES  = 100
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq_pending,
  input wire logic        rst_pin_n,
  input wire logic        flash_brownout_detect,
  input wire logic        hv_fault,
  input wire logic        cpu_stall,
  input wire logic        flash_erase,
  input wire logic [15:0] code_addr,
  input wire logic        boot_rom_select,
  input wire logic [7:0]  boot_rom_index,
  input wire logic        boot_rom_entry,
  input wire logic        icp_clk_oe,
  input wire logic        icp_data_oe,
  input wire logic        serial_loader_mode,
  input wire logic [15:0] start_addr
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        abort_any;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_comb begin
    next_cnt  = cpu_stall ? cnt + 16'h0001 : 16'h0000;
    abort_any = irq_pending | ~rst_pin_n | flash_brownout_detect | hv_fault;
  end
  // stall length is only meaningful for cycles that ran to the end
  always_ff @(posedge aclk) begin
    cnt <= aresetn ? next_cnt : 16'h0000;
  end
  sequence s_cyc_start; $rose(cpu_stall); endsequence
  sequence s_cyc_done; $fell(cpu_stall) && !$past(abort_any); endsequence
  sequence s_rom_hit; code_addr[15:8] == 8'hFF; endsequence
  chk_erase_first: assert property (s_cyc_start |-> flash_erase)
    else $error("cycle did not open with erase");
  chk_cycle_len: assert property (s_cyc_done |-> cnt == 16'(ERASE_CYCLES + PROG_CYCLES))
    else $error("erase-program cycle length wrong");
  chk_abort_stop: assert property (cpu_stall && abort_any |=> !cpu_stall)
    else $error("stall not ended by abort");
  chk_rom_select: assert property (s_rom_hit |=> boot_rom_select && boot_rom_index == $past(code_addr[7:0]))
    else $error("boot rom window not selected");
  chk_rom_entry: assert property (code_addr == 16'hFF00 |=> boot_rom_entry)
    else $error("boot rom entry not flagged");
  chk_status_upper: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
    s_axi_rdata[31:4] == 28'h0) else $error("status upper bits not zero");
  chk_icp_release: assert property (icp_clk_oe && icp_data_oe)
    else $error("programming pins driven");
  chk_loader_vec: assert property (serial_loader_mode |-> start_addr[7:0] == 8'h00)
    else $error("loader start low byte not zero");
endmodule : fppbs_chk
bind fppbs_flash_ctrl fppbs_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) i_fppbs_chk (.*);

// ===== verification/tb_top.sv
// self-checking bench for the flash page program and boot select block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] A_CS = fppbs_pkg::OFS_CMD_STAT;
  localparam logic [7:0] A_AL = fppbs_pkg::OFS_ADDR_LOW;
  localparam logic [7:0] A_BI = fppbs_pkg::OFS_BOOT_INFO;
  localparam logic [1:0] OK   = fppbs_pkg::RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic irq_pending = 1'b0, rst_pin_n = 1'b1, flash_brownout_detect = 1'b0, hv_fault = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall, flash_erase;
  logic flash_strobe, boot_rom_select, boot_rom_entry, icp_clk_out, icp_clk_oe, icp_data_out, icp_data_oe;
  logic serial_loader_mode, start_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flash_wdata, boot_rom_index;
  logic [15:0] flash_addr, start_addr, code_addr = 16'hFEF0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sd = 32'h00011EA6;
  logic [33:0] rq[$];
  logic [23:0] fq[$], fe;
  logic [15:0] pg = 16'h0000;
  logic [3:0]  st[6] = '{4'h0, 4'h9, 4'h1, 4'h4, 4'h8, 4'h2};
  wire logic [3:0] s_axi_wstrb = 4'hF;
  wire logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, icp_clk_in = 1'b1, icp_data_in = 1'b1;
  int num_errors = 0, n_compared = 0;
  fppbs_flash_ctrl #(.ERASE_CYCLES(100), .PROG_CYCLES(100), .BOOT_HOLD_CYCLES(20), .BOOT_QUIET_CYCLES(50))
    i_fppbs_flash_ctrl (.*);
  always #50 aclk = ~aclk;
  always @(posedge aclk) code_addr <= code_addr + 16'h0001;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // valid lines and the flash strobe sampled mid-cycle so the handshake edge is never raced
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && rq.size() > 0) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && bq.size() > 0) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (flash_strobe === 1'b1) begin
      fe = fq.size() > 0 ? fq.pop_front() : 24'hFFFFFF;
      chk("flash", {10'h0, fe}, {10'h0, flash_addr, flash_wdata});
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, dn;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      dn = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic t, dn;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      t = s_axi_arready & s_axi_arvalid;
      dn = s_axi_rvalid;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
    end
  endtask : rd
  task automatic ep(input int k, input logic [3:0] s);
    // a full cycle walks the buffer in both phases, an abort stops it after index 0
    repeat ((k == 0) ? 2 : int'(k < 4)) begin
      fq.push_back({16'h0480, pg[7:0]});
      if (k == 0) fq.push_back({16'h04BF, pg[15:8]});
    end
    if (k == 5) wr(fppbs_pkg::OFS_SECURE, 32'h00000002, OK);
    flash_brownout_detect <= (k == 4);
    wr(A_CS, 32'h00000068, OK);
    if (k == 0) wr(A_AL, 32'h00000033, OK);
    irq_pending <= (k == 1);
    rst_pin_n <= (k != 2);
    hv_fault <= (k == 3);
    @(posedge aclk);
    irq_pending <= 1'b0;
    rst_pin_n <= 1'b1;
    hv_fault <= 1'b0;
    flash_brownout_detect <= 1'b0;
    for (int n = 0; n < 400; n++) begin
      @(negedge aclk);
      if (!cpu_stall) break;
    end
    chk("stall", 34'h0, {33'h0, cpu_stall});
    @(posedge aclk);
    rd(A_CS, {OK, 28'h0, s});
  endtask : ep
  task automatic bt(input int n);
    aresetn <= 1'b0;
    rst_pin_n <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (30) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rst_pin_n <= 1'b1;
      repeat (20) @(posedge aclk);
      rst_pin_n <= 1'b0;
      repeat (20) @(posedge aclk);
    end
    rst_pin_n <= 1'b1;
    repeat (80) @(posedge aclk);
    rd(A_BI, n == 3 ? 34'h000031F00 : 34'h000020000);
  endtask : bt
  task automatic wrap_up;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CS, 34'h0);
    rd(A_BI, 34'h000020000);
    rd(fppbs_pkg::OFS_BOOT_CFG, 34'h000001F00);
    rd(8'h1C, {fppbs_pkg::RESP_SLVERR, 32'h0});
    wr(A_BI, 32'h0, fppbs_pkg::RESP_SLVERR);
    wr(A_CS, 32'h00000000, OK);
    wr(A_AL, 32'h000000BF, OK);
    wr(fppbs_pkg::OFS_ADDR_HIGH, 32'h00000004, OK);
    repeat (2) begin
      sd = xs(sd);
      pg = {pg[7:0], sd[7:0]};
      wr(fppbs_pkg::OFS_PAGE_DATA, sd, OK);
    end
    rd(A_AL, 34'h000000081);
    for (int k = 0; k < 6; k++) ep(k, st[k]);
    chk("strobes left", 34'h0, 34'(fq.size()));
    rd(A_AL, 34'h000000081);
    wr(fppbs_pkg::OFS_PAGE_DATA, sd, OK);
    rd(A_AL, 34'h000000081);
    sd = xs(sd);
    wr(A_CS, {24'h0, sd[7:0] | 8'h01}, OK);
    rd(A_CS, 34'h0);
    wr(fppbs_pkg::OFS_BOOT_CFG, 32'h00001F01, OK);
    rd(A_BI, 34'h000021F00);
    for (int n = 2; n < 5; n++) bt(n);
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule : tb_top
